// ==== hdl/hct_timing.sv ====
// horizontal clock timing core with its serial-written configuration registers
// Function
// - halve bit set makes the step clock run at half the master clock
// - pair one rise from bits 5:0, fall from bits 13:8, fall default 20
// - pair two rise from bits 5:0, fall from bits 13:8, fall default 20
// - last clock rise from bits 5:0, fall from bits 13:8, fall default 20
// - reset gate rise from bits 5:0, fall from bits 13:8, fall default 10
// - polarity bit 16 per group, default 1, cleared inverts the waveform
// - retime bit 0 delays pair one blanking by one pixel cycle
// - retime bit 1 delays pair two blanking by one pixel cycle
// - retime bit 2 delays last clock blanking by one pixel cycle
// - retime bit 3 lets blanking act on the last clock
// - during blanking horizontals run at pixel rate divided by twice the code
module hct_timing
  import hct_pkg::*;
#(
  parameter int STEPS = STEPS_PER_PIXEL
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ser_clock,
  input wire logic ser_data,
  input wire logic ser_load_n,
  input wire logic horizontal_blanking,
  output logic horizontal_phase_one,
  output logic horizontal_phase_two,
  output logic horizontal_phase_three,
  output logic horizontal_phase_four,
  output logic last_horizontal_clock,
  output logic reset_gate_clock
);
  // ******************************
  // pin synchronisers
  // ******************************
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic sck_prev_ff;
  logic sl_prev_ff;
  logic sck_s, sdata_s, sl_s, blank_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 4'h5;
      sync2_ff <= 4'h5;
      sck_prev_ff <= 1'b1;
      sl_prev_ff <= 1'b1;
    end else begin
      sync1_ff <= {horizontal_blanking, ser_load_n, ser_data, ser_clock};
      sync2_ff <= sync1_ff;
      sck_prev_ff <= sync2_ff[0];
      sl_prev_ff <= sync2_ff[2];
    end
  end
  assign sck_s = sync2_ff[0];
  assign sdata_s = sync2_ff[1];
  assign sl_s = sync2_ff[2];
  assign blank_s = sync2_ff[3];

  // ******************************
  // serial port and registers
  // ******************************
  logic [SER_FRAME_BITS-1:0] shift_ff, nxt_shift;
  logic [5:0] bits_ff, nxt_bits;
  logic halve_ff, nxt_halve;
  logic [GROUPS-1:0][16:0] edges_ff, nxt_edges;
  logic [6:0] retime_ff, nxt_retime;
  logic [23:0] drive_ff, nxt_drive;
  logic [7:0] wr_addr;
  logic [23:0] wr_data;
  logic frame_end;

  assign wr_addr = shift_ff[SER_ADDR_BITS-1:0];
  assign wr_data = shift_ff[SER_FRAME_BITS-1:SER_ADDR_BITS];
  assign frame_end = sl_s && !sl_prev_ff && (bits_ff == 6'(SER_FRAME_BITS));

  always_comb begin
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_halve = halve_ff;
    nxt_edges = edges_ff;
    nxt_retime = retime_ff;
    nxt_drive = drive_ff;
    if (sl_s) begin
      nxt_bits = 6'h00;
    end else if (sck_s && !sck_prev_ff && bits_ff != 6'(SER_FRAME_BITS)) begin
      nxt_shift = {sdata_s, shift_ff[SER_FRAME_BITS-1:1]};
      nxt_bits = bits_ff + 6'h01;
    end
    if (frame_end) begin
      case (wr_addr)
        OFS_INPUT_CLOCK_DIVIDE: nxt_halve = wr_data[0];
        OFS_HORIZ_PAIR_A_EDGES: nxt_edges[GRP_PAIR_A] = wr_data[16:0];
        OFS_HORIZ_PAIR_B_EDGES: nxt_edges[GRP_PAIR_B] = wr_data[16:0];
        OFS_LAST_HORIZ_EDGES: nxt_edges[GRP_LAST] = wr_data[16:0];
        OFS_RESET_GATE_EDGES: nxt_edges[GRP_GATE] = wr_data[16:0];
        OFS_BLANKING_RETIME_CONTROL: nxt_retime = wr_data[6:0];
        OFS_HORIZ_DRIVE_STRENGTH: nxt_drive = wr_data;
        default: nxt_drive = drive_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= '0;
      bits_ff <= 6'h00;
      halve_ff <= RST_INPUT_CLOCK_DIVIDE;
      edges_ff <= {RST_GATE_EDGES, RST_HORIZ_EDGES, RST_HORIZ_EDGES, RST_HORIZ_EDGES};
      retime_ff <= RST_RETIME_CONTROL;
      drive_ff <= RST_DRIVE_STRENGTH;
    end else begin
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      halve_ff <= nxt_halve;
      edges_ff <= nxt_edges;
      retime_ff <= nxt_retime;
      drive_ff <= nxt_drive;
    end
  end

  // ******************************
  // step counter and blanking
  // ******************************
  logic div_ff, nxt_div;
  logic [5:0] step_ff, nxt_step;
  logic blank_rt_ff, nxt_blank_rt;
  logic [2:0] slow_cnt_ff, nxt_slow_cnt;
  logic slow_ff, nxt_slow;
  logic step_en, pixel_end;
  logic [2:0] blank_div;

  assign blank_div = retime_ff[POS_BLANK_DIV_LSB +: 3];
  assign step_en = !halve_ff || div_ff;
  assign pixel_end = step_en && (step_ff == 6'(STEPS - 1));

  always_comb begin
    nxt_div = !div_ff;
    nxt_step = step_ff;
    nxt_blank_rt = blank_rt_ff;
    nxt_slow_cnt = slow_cnt_ff;
    nxt_slow = slow_ff;
    if (step_en) begin
      nxt_step = pixel_end ? 6'h00 : step_ff + 6'h01;
    end
    if (pixel_end) begin
      nxt_blank_rt = blank_s;
      // slow phase toggles every code pixels: period of twice the code
      if (!blank_s) begin
        nxt_slow_cnt = 3'h0;
        nxt_slow = 1'b1;
      end else if (slow_cnt_ff >= blank_div - 3'h1) begin
        nxt_slow_cnt = 3'h0;
        nxt_slow = !slow_ff;
      end else begin
        nxt_slow_cnt = slow_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= 1'b0;
      step_ff <= 6'h00;
      blank_rt_ff <= 1'b0;
      slow_cnt_ff <= 3'h0;
      slow_ff <= 1'b1;
    end else begin
      div_ff <= nxt_div;
      step_ff <= nxt_step;
      blank_rt_ff <= nxt_blank_rt;
      slow_cnt_ff <= nxt_slow_cnt;
      slow_ff <= nxt_slow;
    end
  end

  // ******************************
  // edge generators
  // ******************************
  logic [GROUPS-1:0] wave_ff, nxt_wave;
  logic [GROUPS-1:0] out_ff, nxt_out;
  logic [1:0] inv_ff, nxt_inv;
  logic [GROUPS-1:0] grp_blank;
  logic [GROUPS-1:0] grp_resync;

  assign grp_resync = {1'b0, retime_ff[POS_LAST_RESYNC], retime_ff[POS_PAIR_B_RESYNC],
                       retime_ff[POS_PAIR_A_RESYNC]};

  generate
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      logic blank_sel;
      assign blank_sel = grp_resync[g] ? blank_rt_ff : blank_s;
      if (g == GRP_GATE) begin : g_gate
        assign grp_blank[g] = 1'b0;
      end else if (g == GRP_LAST) begin : g_last
        assign grp_blank[g] = blank_sel && retime_ff[POS_LAST_BLANK_EN];
      end else begin : g_pair
        assign grp_blank[g] = blank_sel;
      end
      always_comb begin
        nxt_wave[g] = wave_ff[g];
        if (step_en && step_ff == edges_ff[g][POS_RISE_LSB +: 6]) begin
          nxt_wave[g] = 1'b1;
        end else if (step_en && step_ff == edges_ff[g][POS_FALL_LSB +: 6]) begin
          nxt_wave[g] = 1'b0;
        end
        nxt_out[g] = ((grp_blank[g] && blank_div != 3'h0) ? slow_ff : wave_ff[g])
                     ^ !edges_ff[g][POS_POLARITY];
      end
    end
  endgenerate

  // complementary pair outputs get their own flops so every pin comes from a register
  assign nxt_inv = ~{nxt_out[GRP_PAIR_B], nxt_out[GRP_PAIR_A]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wave_ff <= '0;
      out_ff <= '0;
      inv_ff <= 2'h3;
    end else begin
      wave_ff <= nxt_wave;
      out_ff <= nxt_out;
      inv_ff <= nxt_inv;
    end
  end

  assign horizontal_phase_one = out_ff[GRP_PAIR_A];
  assign horizontal_phase_two = inv_ff[0];
  assign horizontal_phase_three = out_ff[GRP_PAIR_B];
  assign horizontal_phase_four = inv_ff[1];
  assign last_horizontal_clock = out_ff[GRP_LAST];
  assign reset_gate_clock = out_ff[GRP_GATE];

  // ******************************
  // checks
  // ******************************
  chk_halve_rate: assert property (@(posedge clk) disable iff (!reset_n)
    (halve_ff && $past(halve_ff) && step_en) |=> (!step_en || !halve_ff))
    else $error("step advanced on two cycles while halved");
  chk_pair_a_rise: assert property (@(posedge clk) disable iff (!reset_n)
    (step_en && step_ff == edges_ff[0][5:0]) |=> wave_ff[0])
    else $error("pair one rise missed");
  chk_pair_b_fall: assert property (@(posedge clk) disable iff (!reset_n)
    (step_en && step_ff == edges_ff[1][13:8] && step_ff != edges_ff[1][5:0]) |=> !wave_ff[1])
    else $error("pair two fall missed");
  chk_last_rise: assert property (@(posedge clk) disable iff (!reset_n)
    (step_en && step_ff == edges_ff[2][5:0]) |=> wave_ff[2])
    else $error("last clock rise missed");
  chk_gate_follow: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> reset_gate_clock == ($past(wave_ff[3]) ^ !$past(edges_ff[3][16])))
    else $error("reset gate output wrong");
  chk_polarity_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (!grp_blank[0] && !edges_ff[0][16]) |=> horizontal_phase_one == !$past(wave_ff[0]))
    else $error("pair one polarity not applied");
  chk_retime_delay: assert property (@(posedge clk) disable iff (!reset_n)
    pixel_end |=> blank_rt_ff == $past(blank_s))
    else $error("retimed blanking not one pixel late");
  chk_last_no_blank: assert property (@(posedge clk) disable iff (!reset_n)
    !retime_ff[3] |-> !grp_blank[2])
    else $error("blanking reached last clock while disabled");
  chk_slow_period: assert property (@(posedge clk) disable iff (!reset_n)
    (blank_s && pixel_end && blank_div == 3'h1 && $past(blank_s)) |=> $changed(slow_ff))
    else $error("half rate blanking clock did not toggle");
endmodule : hct_timing

// ==== hdl/hct_pkg.sv ====
// constants for the horizontal clock timing core
package hct_pkg;
  // ******************************
  // register offsets
  // ******************************
  localparam logic [7:0] OFS_INPUT_CLOCK_DIVIDE = 8'h30;
  localparam logic [7:0] OFS_HORIZ_PAIR_A_EDGES = 8'h31;
  localparam logic [7:0] OFS_HORIZ_PAIR_B_EDGES = 8'h32;
  localparam logic [7:0] OFS_LAST_HORIZ_EDGES = 8'h33;
  localparam logic [7:0] OFS_RESET_GATE_EDGES = 8'h34;
  localparam logic [7:0] OFS_BLANKING_RETIME_CONTROL = 8'h35;
  localparam logic [7:0] OFS_HORIZ_DRIVE_STRENGTH = 8'h36;
  // ******************************
  // field positions
  // ******************************
  localparam int POS_RISE_LSB = 0;
  localparam int POS_FALL_LSB = 8;
  localparam int POS_POLARITY = 16;
  localparam int POS_PAIR_A_RESYNC = 0;
  localparam int POS_PAIR_B_RESYNC = 1;
  localparam int POS_LAST_RESYNC = 2;
  localparam int POS_LAST_BLANK_EN = 3;
  localparam int POS_BLANK_DIV_LSB = 4;
  // ******************************
  // reset values
  // ******************************
  localparam logic RST_INPUT_CLOCK_DIVIDE = 1'h0;
  localparam logic [16:0] RST_HORIZ_EDGES = 17'h11400;
  localparam logic [16:0] RST_GATE_EDGES = 17'h10a00;
  localparam logic [6:0] RST_RETIME_CONTROL = 7'h00;
  localparam logic [23:0] RST_DRIVE_STRENGTH = 24'h111111;
  // ******************************
  // serial frame and timing counts
  // ******************************
  localparam int SER_ADDR_BITS = 8;
  localparam int SER_DATA_BITS = 24;
  localparam int SER_FRAME_BITS = SER_ADDR_BITS + SER_DATA_BITS;
  localparam int STEPS_PER_PIXEL = 64;
  localparam int GROUPS = 4;
  localparam int GRP_PAIR_A = 0;
  localparam int GRP_PAIR_B = 1;
  localparam int GRP_LAST = 2;
  localparam int GRP_GATE = 3;
endpackage : hct_pkg

// ==== sim/hct_ccd_model.sv ====
// sensor-side observer that measures run lengths of ph1, ph3, lastclk and gate, and checks ph2 and ph4 against ph1 and ph3
module hct_ccd_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] pins,
  input wire logic ph2,
  input wire logic ph4,
  output logic [3:0][15:0] hi_len,
  output logic [3:0][15:0] lo_len,
  output logic pair_fault
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0][15:0] run;
  logic [3:0] last;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= '0;
      last <= '0;
      hi_len <= '0;
      lo_len <= '0;
      pair_fault <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pins[i] !== last[i]) begin
          if (last[i]) hi_len[i] <= run[i];
          else lo_len[i] <= run[i];
          run[i] <= 16'h0001;
        end else begin
          run[i] <= run[i] + 16'h0001;
        end
      end
      last <= pins;
      if (ph2 !== !pins[0] || ph4 !== !pins[1]) pair_fault <= 1'b1;
    end
  end
endmodule : hct_ccd_model

// ==== sim/ccd_horizontal_clock_timing_tb_top.sv ====
// self-checking bench for the horizontal clock timing core
module ccd_horizontal_clock_timing_tb_top
  import hct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, ser_clock, ser_data, ser_load_n, hblank;
  logic ph1, ph2, ph3, ph4, lastclk, gate, fault;
  logic [3:0][15:0] hi, lo;
  logic [15:0] exp_hi [4];
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  hct_timing hct_timing_i (.clk(clk), .reset_n(reset_n), .ser_clock(ser_clock),
    .ser_data(ser_data), .ser_load_n(ser_load_n), .horizontal_blanking(hblank),
    .horizontal_phase_one(ph1), .horizontal_phase_two(ph2), .horizontal_phase_three(ph3),
    .horizontal_phase_four(ph4), .last_horizontal_clock(lastclk), .reset_gate_clock(gate));
  hct_ccd_model hct_ccd_model_i (.clk(clk), .reset_n(reset_n),
    .pins({gate, lastclk, ph3, ph1}), .ph2(ph2), .ph4(ph4), .hi_len(hi), .lo_len(lo),
    .pair_fault(fault));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk
  // lsb first: address byte then data
  task automatic frame(input logic [31:0] f, input int n);
    @(posedge clk);
    ser_load_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      ser_data <= f[i];
      ser_clock <= 1'b0;
      tick(4);
      ser_clock <= 1'b1;
      tick(4);
    end
    ser_load_n <= 1'b1;
    tick(8);
  endtask : frame
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    frame({d, a}, 32);
  endtask : wr
  function automatic logic [15:0] hi_of(input int r, input int f, input logic p);
    return p ? 16'(f - r) : 16'(STEPS_PER_PIXEL - (f - r));
  endfunction : hi_of
  task automatic t_reset;
    chk("ph1 in reset", 16'h0, {15'h0, ph1});
    chk("ph2 in reset", 16'h1, {15'h0, ph2});
    chk("gate in reset", 16'h0, {15'h0, gate});
    @(posedge clk);
    reset_n <= 1'b1;
    tick(400);
    chk("ph1 high", 16'd20, hi[0]);
    chk("ph1 low", 16'd44, lo[0]);
    chk("ph3 high", 16'd20, hi[1]);
    chk("lastclk high", 16'd20, hi[2]);
    chk("gate high", 16'd10, hi[3]);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edges;
    logic p;
    for (int g = 0; g < 4; g++) begin
      p = g[0];
      wr(8'(OFS_HORIZ_PAIR_A_EDGES + g), {7'h0, p, 2'h0, 6'd40, 2'h0, 6'(3 + g)});
      exp_hi[g] = hi_of(3 + g, 40, p);
    end
    tick(400);
    chk("ph1 edges", exp_hi[0], hi[0]);
    chk("ph3 edges", exp_hi[1], hi[1]);
    chk("lastclk edges", exp_hi[2], hi[2]);
    chk("gate edges", exp_hi[3], hi[3]);
    chk("pair fault", 16'h0, {15'h0, fault});
    $display("test edges done");
  endtask : t_edges
  task automatic t_refuse;
    // top data bit left in the shifter makes a short frame alias a pair one write
    wr(8'h3f, 24'h813200);
    frame({1'b0, 24'h013200, 7'h18}, 31);
    wr(OFS_HORIZ_DRIVE_STRENGTH, 24'h0);
    tick(400);
    chk("ph1 after refused", exp_hi[0], hi[0]);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_halve;
    wr(OFS_HORIZ_PAIR_A_EDGES, 24'h011400);
    exp_hi[0] = 16'd20;
    wr(OFS_INPUT_CLOCK_DIVIDE, 24'h1);
    tick(600);
    chk("ph1 high halved", 16'd40, hi[0]);
    chk("ph1 low halved", 16'd88, lo[0]);
    wr(OFS_INPUT_CLOCK_DIVIDE, 24'h0);
    $display("test halve done");
  endtask : t_halve
  task automatic t_blank;
    logic [15:0] s;
    for (int k = 0; k < 8; k++) begin
      wr(OFS_BLANKING_RETIME_CONTROL, {17'h0, 3'(k), k[0], 3'(k)});
      hblank <= 1'b1;
      tick(384 * k + 400);
      s = 16'(64 * k);
      chk("ph1 blank", (k == 0) ? exp_hi[0] : s, hi[0]);
      chk("ph3 blank", (k == 0) ? exp_hi[1] : s, hi[1]);
      chk("lastclk blank", k[0] ? s : exp_hi[2], hi[2]);
      chk("gate blank", exp_hi[3], hi[3]);
      hblank <= 1'b0;
      tick(200);
    end
    $display("test blank done");
  endtask : t_blank
  task automatic summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    reset_n = 1'b0;
    ser_clock = 1'b1;
    ser_data = 1'b0;
    ser_load_n = 1'b1;
    hblank = 1'b0;
    exp_hi = '{16'd20, 16'd20, 16'd20, 16'd10};
    tick(20);
    t_reset();
    t_edges();
    t_refuse();
    t_halve();
    t_blank();
    summarize();
  end
endmodule : ccd_horizontal_clock_timing_tb_top
